// File: aig_pkg.sv
// Constants for the amplifier, input selector and result register block
// Functional notes
// - Gain field bits 7:5: codes 0 to 4 give gain 1,2,4,8,16; rest reserved.
// - Bias field bits 4:3: codes 0 to 3 give 100,75,50,25 percent bias current.
// - Amplifier sample length bits 2:1: 6, 15, 20 converter clocks; code 3 reserved.
// - Amplifier enable bit 0 powers amplifier only while routing selects the amplifier or the low-latency bit is set.
// - Enable plus low-latency bit keeps the amplifier powered whatever the routing.
// - Routing field bits 7:6: 0 direct, 1 through amplifier, others reserved.
// - One shared routing copy; writing it via either selector updates both readbacks.
// - Positive selector: ground, pins 1-15, ground, supply/10, temperature, reference.
// - Negative selector: ground, pins 1-7, ground, supply/10, reference; temperature reserved.
// - Result is four read-only byte registers, byte n at base plus n, reset zero.
// - Start code 2 starts on positive selector write, code 3 on negative write.
// - With amplifier path, input sampling lasts sample length plus one converter clocks.
package aig_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W = 6;
  localparam logic [5:0] IDX_AUX = 6'h00;
  localparam logic [5:0] IDX_SLEN = 6'h08;
  localparam logic [5:0] IDX_CMD = 6'h0A;
  localparam logic [5:0] IDX_AMP = 6'h0B;
  localparam logic [5:0] IDX_POS = 6'h0C;
  localparam logic [5:0] IDX_NEG = 6'h0D;
  localparam logic [5:0] IDX_STAT = 6'h0E;
  localparam logic [5:0] IDX_RES0 = 6'h10;
  localparam logic [5:0] IDX_RES1 = 6'h11;
  localparam logic [5:0] IDX_RES2 = 6'h12;
  localparam logic [5:0] IDX_RES3 = 6'h13;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AMP_RST = 8'h04;
  localparam logic [5:0] SEL_RST = 6'h00;
  localparam logic [1:0] VIA_RST = 2'h0;
  localparam logic [7:0] SLEN_RST = 8'h00;
  localparam logic [2:0] START_RST = 3'h0;
  localparam logic [31:0] RES_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned GAIN_LSB = 5;
  localparam int unsigned BIAS_LSB = 3;
  localparam int unsigned ASL_LSB = 1;
  localparam int unsigned AMP_ON_BIT = 0;
  localparam int unsigned VIA_LSB = 6;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SELECT_A_BIT = 7;
  localparam int unsigned START_LSB = 0;
  localparam int unsigned LLAT_BIT = 0;
  localparam int unsigned STAT_POWER_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  // ----------------------------------------------------------------
  // Codes and decoded values
  // ----------------------------------------------------------------
  localparam logic [1:0] VIA_DIRECT = 2'h0;
  localparam logic [1:0] VIA_AMP = 2'h1;
  localparam logic [2:0] START_POS = 3'h2;
  localparam logic [2:0] START_NEG = 3'h3;
  localparam logic [2:0] GAIN_MAX = 3'h4;
  localparam logic [5:0] SEL_GND0 = 6'h00;
  localparam logic [5:0] POS_PIN_MAX = 6'h0F;
  localparam logic [5:0] NEG_PIN_MAX = 6'h07;
  localparam logic [5:0] SEL_GND = 6'h30;
  localparam logic [5:0] SEL_VDIV = 6'h31;
  localparam logic [5:0] SEL_TEMP = 6'h32;
  localparam logic [5:0] SEL_DREF = 6'h33;
  localparam logic [4:0] ASL_CYC0 = 5'h06;
  localparam logic [4:0] ASL_CYC1 = 5'h0F;
  localparam logic [4:0] ASL_CYC2 = 5'h14;
  localparam logic [6:0] BIAS_PCT0 = 7'h64;
  localparam logic [6:0] BIAS_PCT1 = 7'h4B;
  localparam logic [6:0] BIAS_PCT2 = 7'h32;
  localparam logic [6:0] BIAS_PCT3 = 7'h19;
endpackage

// File: aig_regs.sv
// Amplifier control, input selectors and result registers on classic Wishbone
`timescale 1ns/10ps
`default_nettype none
module aig_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [31:0] result_i,
  input wire logic result_valid_i,
  output logic [2:0] gain_code_o,
  output logic [4:0] gain_factor_o,
  output logic [1:0] bias_code_o,
  output logic [6:0] bias_pct_o,
  output logic [4:0] amp_sample_cycles_o,
  output logic amp_power_o,
  output logic route_amp_o,
  output logic [5:0] pos_sel_o,
  output logic pos_sel_valid_o,
  output logic [5:0] neg_sel_o,
  output logic neg_sel_valid_o,
  output logic select_a_o,
  output logic [8:0] input_sample_cycles_o,
  output logic conv_start_o,
  output logic [aig_pkg::IDX_W-1:0] last_index_o
);
  import aig_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic ack;
  logic [31:0] rdata;
  logic [2:0] gain;
  logic [1:0] bias;
  logic [1:0] amp_sample_len;
  logic amp_on;
  logic [1:0] via;
  logic [5:0] pos_input_sel;
  logic [5:0] neg_input_sel;
  logic [7:0] input_sample_len;
  logic select_a;
  logic [2:0] start_mode;
  logic low_latency_keep;
  logic [31:0] result;
  logic busy;
  logic [IDX_W-1:0] last_index;

  logic next_ack;
  logic [31:0] next_rdata;
  logic [2:0] next_gain;
  logic [1:0] next_bias;
  logic [1:0] next_amp_sample_len;
  logic next_amp_on;
  logic [1:0] next_via;
  logic [5:0] next_pos_input_sel;
  logic [5:0] next_neg_input_sel;
  logic [7:0] next_input_sample_len;
  logic next_select_a;
  logic [2:0] next_start_mode;
  logic next_low_latency_keep;
  logic [31:0] next_result;
  logic next_busy;
  logic [IDX_W-1:0] next_last_index;

  logic req;
  logic commit;
  logic start_req;
  logic [IDX_W-1:0] idx;
  logic [7:0] wbyte;

  // ----------------------------------------------------------------
  // Bus decode and register update
  // ----------------------------------------------------------------
  always_comb begin
    req = cyc_i & stb_i;
    idx = adr_i[7:2];
    wbyte = dat_i[7:0];
    commit = req & we_i & ack & sel_i[0];
    next_ack = req & ~ack;
    next_gain = gain;
    next_bias = bias;
    next_amp_sample_len = amp_sample_len;
    next_amp_on = amp_on;
    next_via = via;
    next_pos_input_sel = pos_input_sel;
    next_neg_input_sel = neg_input_sel;
    next_input_sample_len = input_sample_len;
    next_select_a = select_a;
    next_start_mode = start_mode;
    next_low_latency_keep = low_latency_keep;
    next_last_index = last_index;
    start_req = 1'b0;
    if (commit) begin
      next_last_index = idx;
      unique case (idx)
        IDX_AUX: begin
          next_low_latency_keep = wbyte[LLAT_BIT];
        end
        IDX_SLEN: begin
          next_input_sample_len = wbyte;
        end
        IDX_CMD: begin
          next_select_a = wbyte[SELECT_A_BIT];
          next_start_mode = wbyte[START_LSB +: 3];
        end
        IDX_AMP: begin
          next_gain = wbyte[GAIN_LSB +: 3];
          next_bias = wbyte[BIAS_LSB +: 2];
          next_amp_sample_len = wbyte[ASL_LSB +: 2];
          next_amp_on = wbyte[AMP_ON_BIT];
        end
        IDX_POS: begin
          next_via = wbyte[VIA_LSB +: 2];
          next_pos_input_sel = wbyte[SEL_LSB +: 6];
          start_req = (start_mode == START_POS);
        end
        IDX_NEG: begin
          next_via = wbyte[VIA_LSB +: 2];
          next_neg_input_sel = wbyte[SEL_LSB +: 6];
          start_req = (start_mode == START_NEG);
        end
        default: begin
          next_last_index = last_index;
        end
      endcase
    end
    // Result captured from the core only; bus writes never reach it
    next_result = result_valid_i ? result_i : result;
    next_busy = start_req | (busy & ~result_valid_i);
    next_rdata = 32'h0000_0000;
    if (req & ~ack) begin
      unique case (idx)
        IDX_AUX: next_rdata[LLAT_BIT] = low_latency_keep;
        IDX_SLEN: next_rdata[7:0] = input_sample_len;
        IDX_CMD: next_rdata[7:0] = {select_a, 4'h0, start_mode};
        IDX_AMP: next_rdata[7:0] = {gain, bias, amp_sample_len, amp_on};
        IDX_POS: next_rdata[7:0] = {via, pos_input_sel};
        IDX_NEG: next_rdata[7:0] = {via, neg_input_sel};
        IDX_STAT: next_rdata[1:0] = {busy, amp_power_o};
        IDX_RES0: next_rdata[7:0] = result[7:0];
        IDX_RES1: next_rdata[7:0] = result[15:8];
        IDX_RES2: next_rdata[7:0] = result[23:16];
        IDX_RES3: next_rdata[7:0] = result[31:24];
        default: next_rdata = 32'h0000_0000;
      endcase
    end else if (ack) begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      gain <= AMP_RST[GAIN_LSB +: 3];
      bias <= AMP_RST[BIAS_LSB +: 2];
      amp_sample_len <= AMP_RST[ASL_LSB +: 2];
      amp_on <= AMP_RST[AMP_ON_BIT];
      via <= VIA_RST;
      pos_input_sel <= SEL_RST;
      neg_input_sel <= SEL_RST;
      input_sample_len <= SLEN_RST;
      select_a <= 1'b0;
      start_mode <= START_RST;
      low_latency_keep <= 1'b0;
      result <= RES_RST;
      busy <= 1'b0;
      last_index <= IDX_AUX;
      conv_start_o <= 1'b0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      gain <= next_gain;
      bias <= next_bias;
      amp_sample_len <= next_amp_sample_len;
      amp_on <= next_amp_on;
      via <= next_via;
      pos_input_sel <= next_pos_input_sel;
      neg_input_sel <= next_neg_input_sel;
      input_sample_len <= next_input_sample_len;
      select_a <= next_select_a;
      start_mode <= next_start_mode;
      low_latency_keep <= next_low_latency_keep;
      result <= next_result;
      busy <= next_busy;
      last_index <= next_last_index;
      conv_start_o <= start_req;
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;
  assign last_index_o = last_index;

  // ----------------------------------------------------------------
  // Analog side decode
  // ----------------------------------------------------------------
  logic [4:0] next_gain_factor;
  logic [6:0] next_bias_pct;
  logic [4:0] next_amp_cycles;
  logic next_amp_power;
  logic next_pos_valid;
  logic next_neg_valid;
  logic [8:0] next_input_cycles;

  always_comb begin
    next_gain_factor = (gain <= GAIN_MAX) ? 5'(5'h01 << gain) : 5'h00;
    unique case (bias)
      2'h0: next_bias_pct = BIAS_PCT0;
      2'h1: next_bias_pct = BIAS_PCT1;
      2'h2: next_bias_pct = BIAS_PCT2;
      2'h3: next_bias_pct = BIAS_PCT3;
    endcase
    unique case (amp_sample_len)
      2'h0: next_amp_cycles = ASL_CYC0;
      2'h1: next_amp_cycles = ASL_CYC1;
      2'h2: next_amp_cycles = ASL_CYC2;
      2'h3: next_amp_cycles = 5'h00;
    endcase
    next_amp_power = amp_on & ((via == VIA_AMP) | low_latency_keep);
    next_pos_valid = (pos_input_sel <= POS_PIN_MAX)
      | ((pos_input_sel >= SEL_GND) & (pos_input_sel <= SEL_DREF));
    next_neg_valid = (neg_input_sel <= NEG_PIN_MAX)
      | (neg_input_sel == SEL_GND) | (neg_input_sel == SEL_VDIV)
      | (neg_input_sel == SEL_DREF);
    if (via == VIA_AMP) begin
      next_input_cycles = {1'b0, input_sample_len} + 9'h001;
    end else begin
      next_input_cycles = {1'b0, input_sample_len};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_code_o <= AMP_RST[GAIN_LSB +: 3];
      gain_factor_o <= 5'h01;
      bias_code_o <= AMP_RST[BIAS_LSB +: 2];
      bias_pct_o <= BIAS_PCT0;
      amp_sample_cycles_o <= ASL_CYC0;
      amp_power_o <= 1'b0;
      route_amp_o <= 1'b0;
      pos_sel_o <= SEL_GND0;
      pos_sel_valid_o <= 1'b1;
      neg_sel_o <= SEL_GND0;
      neg_sel_valid_o <= 1'b1;
      select_a_o <= 1'b0;
      input_sample_cycles_o <= 9'h000;
    end else begin
      gain_code_o <= gain;
      gain_factor_o <= next_gain_factor;
      bias_code_o <= bias;
      bias_pct_o <= next_bias_pct;
      amp_sample_cycles_o <= next_amp_cycles;
      amp_power_o <= next_amp_power;
      route_amp_o <= (via == VIA_AMP);
      pos_sel_o <= pos_input_sel;
      pos_sel_valid_o <= next_pos_valid;
      neg_sel_o <= neg_input_sel;
      neg_sel_valid_o <= next_neg_valid;
      select_a_o <= select_a;
      input_sample_cycles_o <= next_input_cycles;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pos_start;
    commit && idx == IDX_POS && start_mode == START_POS;
  endsequence
  sequence s_neg_start;
    commit && idx == IDX_NEG && start_mode == START_NEG;
  endsequence
  sequence s_pulse;
    conv_start_o ##1 !conv_start_o;
  endsequence

  a_gain_decode: assert property (
    gain == 3'h3 |=> gain_factor_o == 5'h08) else $error("gain decode wrong");
  a_gain_reserved: assert property (
    gain > GAIN_MAX |=> gain_factor_o == 5'h00) else $error("reserved gain");
  a_bias_decode: assert property (
    bias == 2'h1 |=> bias_pct_o == 7'h4B && bias_code_o == 2'h1)
    else $error("bias decode wrong");
  a_amp_sample_len: assert property (
    amp_sample_len == 2'h2 |=> amp_sample_cycles_o == 5'h14)
    else $error("amp sample length wrong");
  a_amp_off_direct: assert property (
    (via != VIA_AMP && !low_latency_keep) |=> !amp_power_o)
    else $error("amp powered off path");
  a_amp_keep_on: assert property (
    (amp_on && low_latency_keep) |=> amp_power_o) else $error("amp not kept on");
  a_route_amp: assert property (
    route_amp_o == $past(via == VIA_AMP)) else $error("route output wrong");
  a_shared_route: assert property (
    (commit && (idx == IDX_POS || idx == IDX_NEG)) |=> via == $past(wbyte[VIA_LSB +: 2]))
    else $error("shared routing not updated");
  a_pos_sel_valid: assert property (
    pos_input_sel == SEL_TEMP |=> pos_sel_valid_o) else $error("temp pos invalid");
  a_neg_temp_res: assert property (
    neg_input_sel == SEL_TEMP |=> !neg_sel_valid_o) else $error("temp neg valid");
  a_result_bytes: assert property (
    (req && !ack && !we_i && idx == IDX_RES2) |=> ack_o && dat_o == {24'h0, $past(result[23:16])})
    else $error("result byte read wrong");
  a_start_pos: assert property (
    s_pos_start |=> s_pulse) else $error("no start on pos write");
  a_start_neg: assert property (
    s_neg_start |=> s_pulse) else $error("no start on neg write");
  a_no_spurious: assert property (
    !(commit && (idx == IDX_POS || idx == IDX_NEG)) |=> !conv_start_o)
    else $error("spurious start");
  a_select_a_select: assert property (
    select_a |=> select_a_o) else $error("select_a not driven");
  a_input_len: assert property (
    via == VIA_AMP |=> input_sample_cycles_o == {1'b0, $past(input_sample_len)} + 9'h001)
    else $error("input sample length wrong");
  a_result_ro: assert property (
    (commit && idx >= IDX_RES0 && idx <= IDX_RES3 && !result_valid_i) |=> $stable(result))
    else $error("result written by bus");
  a_ack_single: assert property (
    ack_o |=> !ack_o) else $error("ack held too long");
endmodule // aig_regs
`default_nettype wire

// File: aig_core_model.sv
// Converter core stand-in: answers a start pulse with a result; a start during a conversion restarts the count
`timescale 1ns/10ps
`default_nettype none
module aig_core_model #(
  parameter int LAT = 12,
  parameter logic [31:0] BASE = 32'hC3A5_1E00
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic [31:0] result_o,
  output logic valid_o
);
  int cnt;
  logic [31:0] seq;
  // ----------------------------------------------------------------
  // Conversion timer and result bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    valid_o <= 1'b0;
    // Released bus keeps changing between results
    result_o <= ~result_o;
    if (rst_i) begin
      cnt <= 0;
      seq <= 32'h0;
      result_o <= 32'h0;
    end else if (start_i) begin
      cnt <= LAT;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      seq <= seq + 32'h1;
      result_o <= BASE + seq + 32'h1;
      valid_o <= 1'b1;
    end
  end
endmodule // aig_core_model
`default_nettype wire

// File: tb.sv
// Register-level testbench for the amplifier and input selector block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import aig_pkg::*;
  localparam logic [31:0] RES_BASE = 32'hC3A5_1E00;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, result, rd, e;
  logic ack_o, rvalid, amp_power_o, route_amp_o, pos_sel_valid_o, neg_sel_valid_o;
  logic select_a_o, conv_start_o, pv, nv;
  logic [2:0] gain_code_o;
  logic [4:0] gain_factor_o, amp_sample_cycles_o;
  logic [1:0] bias_code_o;
  logic [6:0] bias_pct_o;
  logic [5:0] pos_sel_o, neg_sel_o, last_index_o, c;
  logic [8:0] input_sample_cycles_o;
  logic [7:0] v;
  logic [31:0] pct [4] = '{32'h64, 32'h4B, 32'h32, 32'h19};
  logic [31:0] asl [4] = '{32'h06, 32'h0F, 32'h14, 32'h00};
  logic [5:0] codes [11] = '{6'h00, 6'h01, 6'h07, 6'h08, 6'h0F, 6'h10, 6'h30, 6'h31, 6'h32,
                             6'h33, 6'h3F};
  int n_mismatch = 0;
  int checks = 0;
  int n_start = 0;
  int cycles = 0;
  int n0;

  aig_regs u_aig_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .result_i(result), .result_valid_i(rvalid), .gain_code_o(gain_code_o),
    .gain_factor_o(gain_factor_o), .bias_code_o(bias_code_o), .bias_pct_o(bias_pct_o),
    .amp_sample_cycles_o(amp_sample_cycles_o), .amp_power_o(amp_power_o),
    .route_amp_o(route_amp_o), .pos_sel_o(pos_sel_o), .pos_sel_valid_o(pos_sel_valid_o),
    .neg_sel_o(neg_sel_o), .neg_sel_valid_o(neg_sel_valid_o), .select_a_o(select_a_o),
    .input_sample_cycles_o(input_sample_cycles_o), .conv_start_o(conv_start_o),
    .last_index_o(last_index_o));
  aig_core_model #(.LAT(12), .BASE(RES_BASE)) u_aig_core_model (.clk_i(clk_i),
    .rst_i(rst_i), .start_i(conv_start_o), .result_o(result), .valid_o(rvalid));

  always #12.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // Start pulse counter and timeout
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) begin
      n_start <= n_start + 1;
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_result;
    int n;
    n = 0;
    while (rvalid !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) begin
      n_mismatch++;
    end
    tick(1);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(IDX_AMP, 32'h04);
    rdc(IDX_POS, 32'h00);
    rdc(IDX_NEG, 32'h00);
    for (int b = 0; b < 4; b++) begin
      rdc(6'(IDX_RES0 + b), 32'h00);
    end
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], i[1:0], i[1:0], 1'b0};
      wr(IDX_AMP, v);
      tick(2);
      rdc(IDX_AMP, {24'h0, v});
      chk(32'(gain_code_o), 32'(i[2:0]));
      chk(32'(gain_factor_o), i < 5 ? 32'h1 << i : 32'h0);
      chk(32'(bias_pct_o), pct[i % 4]);
      chk(32'(bias_code_o), 32'(i[1:0]));
      chk(32'(amp_sample_cycles_o), asl[i % 4]);
    end
    wr(IDX_AMP, 8'h01);
    wr(IDX_POS, 8'h05);
    tick(2);
    chk(32'(amp_power_o), 32'h0);
    wr(IDX_POS, 8'h45);
    tick(2);
    chk(32'(amp_power_o), 32'h1);
    chk(32'(route_amp_o), 32'h1);
    rdc(IDX_NEG, 32'h40);
    wr(IDX_NEG, 8'h83);
    tick(2);
    chk(32'(route_amp_o), 32'h0);
    rdc(IDX_POS, 32'h85);
    wr(IDX_NEG, 8'h03);
    wr(IDX_AUX, 8'h01);
    tick(2);
    chk(32'(amp_power_o), 32'h1);
    wr(IDX_AMP, 8'h00);
    tick(2);
    chk(32'(amp_power_o), 32'h0);
    wr(IDX_AUX, 8'h00);
    foreach (codes[k]) begin
      c = codes[k];
      pv = c <= 6'h0F || (c >= 6'h30 && c <= 6'h33);
      nv = c <= 6'h07 || c == 6'h30 || c == 6'h31 || c == 6'h33;
      wr(IDX_POS, {2'b00, c});
      wr(IDX_NEG, {2'b00, c});
      tick(2);
      chk(32'(pos_sel_o), 32'(c));
      chk(32'(pos_sel_valid_o), 32'(pv));
      chk(32'(neg_sel_o), 32'(c));
      chk(32'(neg_sel_valid_o), 32'(nv));
    end
    wr(IDX_SLEN, 8'hFF);
    tick(2);
    chk(32'(input_sample_cycles_o), 32'hFF);
    wr(IDX_POS, 8'h40);
    tick(2);
    chk(32'(input_sample_cycles_o), 32'h100);
    wr(IDX_CMD, 8'h80);
    tick(2);
    chk(32'(select_a_o), 32'h1);
    wr(IDX_CMD, 8'h02);
    tick(2);
    chk(32'(select_a_o), 32'h0);
    n0 = n_start;
    wr(IDX_NEG, 8'h01);
    tick(2);
    chk(n_start, n0);
    wr(IDX_POS, 8'h01);
    tick(2);
    chk(n_start, n0 + 1);
    rdc(IDX_STAT, 32'h2);
    wait_result();
    rdc(IDX_STAT, 32'h0);
    e = RES_BASE + 32'h1;
    for (int b = 0; b < 4; b++) begin
      rdc(6'(IDX_RES0 + b), {24'h0, e[8*b +: 8]});
    end
    wr(IDX_RES1, 8'h5A);
    rdc(IDX_RES1, {24'h0, e[15:8]});
    chk(32'(last_index_o), 32'(IDX_POS));
    wr(IDX_CMD, 8'h03);
    wr(IDX_POS, 8'h02);
    tick(2);
    chk(n_start, n0 + 1);
    wr(IDX_NEG, 8'h02);
    tick(2);
    chk(n_start, n0 + 2);
    wait_result();
    e = RES_BASE + 32'h2;
    rdc(IDX_RES0, {24'h0, e[7:0]});
    rdc(IDX_RES3, {24'h0, e[31:24]});
    rdc(6'h3F, 32'h00);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
